// [iir_filters_and_level_limiter.sv]
// Summary of operation
// - shape 0: stage is first-order high-pass
// - shape 1: stage is first-order low-pass
// - shelf stage: (A + C z^-1)/(1 + B z^-1)
// - coefficients are Q13 two's complement, signed
// - level control runs only while enabled
// - adc power picks record path, dac playback
// - either channel hot: attenuate both, equal volumes
// - zero-cross mode: apply at crossing or timeout
// - timeout is 128, 256, 512, 1024 samples
// - zero-cross off: one step every hot sample
// - keep attenuating while hot, rearm later
// - detection level -2.5/-4.1/-6.0/-8.5 dBFS
// - threshold also sets wait reset band
// - step select gives 1, 2, 4, 8 steps in zero-cross mode
// - disabled: stage1/shelf pass, stage3 mutes
module iir_filters_and_level_limiter
   import iir_alc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // sample inputs
   input wire stereo_s rec_in,
   input wire logic rec_valid,
   input wire stereo_s play_in,
   input wire logic play_valid,
   // processed samples
   output stereo_s proc_out,
   output logic proc_valid,
   output logic path_rec,
   output logic path_play
);

   // saturate a wide value to 16 bits
   function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
      if (v > 48'sh7fff) begin
         return 16'sh7fff;
      end else if (v < -48'sh8000) begin
         return -16'sh8000;
      end else begin
         return v[15:0];
      end
   endfunction : sat16

   // generic first-order section y = (a x + c x1 - b y1) / 2^13
   function automatic logic signed [15:0] first_order(input logic signed [15:0] x,
         input logic signed [15:0] x1, input logic signed [15:0] y1,
         input logic signed [16:0] a, input logic signed [16:0] c, input logic signed [13:0] b);
      logic signed [47:0] acc;
      acc = 48'(a) * 48'(x) + 48'(c) * 48'(x1) - 48'(b) * 48'(y1);
      return sat16(acc >>> COEF_FRAC);
   endfunction : first_order

   // 0.375 dB per code, unity at VOL_UNITY, code 0 mutes
   function automatic logic signed [15:0] vol_apply(input logic signed [15:0] x,
         input logic [7:0] code);
      logic signed [9:0] n;
      logic signed [5:0] sh;
      logic signed [47:0] prod;
      n = $signed({2'b00, code}) - $signed({2'b00, VOL_UNITY});
      sh = 6'(n >>> 4);
      prod = 48'(x) * 48'($signed({1'b0, VOL_MANT[n[3:0]]}));
      if (code == 8'h00) begin
         return 16'sh0000;
      end else if (sh >= 0) begin
         return sat16((prod <<< sh) >>> VOL_FRAC);
      end else begin
         return sat16(prod >>> (VOL_FRAC - sh));
      end
   endfunction : vol_apply

   // detection level per threshold code
   function automatic logic [16:0] detect_level(input logic [1:0] sel);
      case (sel)
         2'b00: return LVL_M2P5;
         2'b01: return LVL_M4P1;
         2'b10: return LVL_M6P0;
         default: return LVL_M8P5;
      endcase
   endfunction : detect_level

   // lower edge of the wait reset band per threshold code
   function automatic logic [16:0] band_floor(input logic [1:0] sel);
      case (sel)
         2'b00: return LVL_M4P1;
         2'b01: return LVL_M6P0;
         2'b10: return LVL_M8P5;
         default: return LVL_M12;
      endcase
   endfunction : band_floor

   // magnitude without overflow at full negative scale
   function automatic logic [16:0] mag(input logic signed [15:0] v);
      return v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
   endfunction : mag

   // merge write data into a register under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // register file
   logic [31:0] ctrl_r; // enables, shapes, limiter fields, power
   logic [31:0] stage1_r; // stage1 a low half, b high half
   logic [31:0] stage3_r; // stage3 a low half, b high half
   logic [31:0] shelf_ac_r; // shelf a low half, c high half
   logic [31:0] shelf_b_r; // shelf b low bits
   logic [7:0] vol_r [2]; // current left/right input volume
   logic ack_r; // single-cycle acknowledge
   logic [31:0] dat_r; // registered read data
   logic wr_go; // write takes effect this edge
   logic [31:0] status_w; // live status word

   // filter history per channel and stage
   logic signed [15:0] x1_r [2][3];
   logic signed [15:0] y1_r [2][3];
   logic signed [15:0] xin [2]; // selected input sample
   logic signed [15:0] s1 [2]; // stage1 output
   logic signed [15:0] s2 [2]; // shelf output
   logic signed [15:0] s3 [2]; // stage3 output
   logic signed [15:0] sv [2]; // after volume
   logic signed [15:0] prev_r [2]; // last output for zero crossing

   // limiter state
   lim_state_e lim_state_r;
   logic [10:0] tmo_cnt_r; // samples waited for crossing
   logic [7:0] target_r; // pending volume
   logic [1:0] applied_r; // channels already moved
   logic hot_r; // last sample at or above detection
   logic band_r; // last sample inside wait reset band

   // decoded fields
   logic rec_sel, play_sel, tick, alc_on, zc_dis, hot, in_band;
   logic [1:0] zc;
   logic [10:0] tmo_lim;
   logic [7:0] step, vmin;
   stereo_s src;

   // path choice by power bits
   assign rec_sel = ctrl_r[CTL_ADC_L] | ctrl_r[CTL_ADC_R];
   assign play_sel = ctrl_r[CTL_DAC] & ~rec_sel;
   assign src = rec_sel ? rec_in : play_in;
   assign tick = rec_sel ? rec_valid : (play_sel & play_valid);
   assign alc_on = ctrl_r[CTL_ALC_EN] & (rec_sel | play_sel);
   assign zc_dis = ctrl_r[CTL_ZC_DIS];
   assign tmo_lim = ZTO_BASE << ctrl_r[CTL_ZTM_LSB +: 2];
   // fixed single step without zero crossing, else 1/2/4/8
   assign step = zc_dis ? 8'h01 : (8'h01 << ctrl_r[CTL_LMAT_LSB +: 2]);
   assign vmin = (vol_r[0] < vol_r[1]) ? vol_r[0] : vol_r[1];
   assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;

   // sample datapath through the three stages and volume
   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         xin[ch] = (ch == 0) ? src.left : src.right;
         // stage1: sign-extended coefficients, c = -a for high-pass, +a for low-pass
         if (ctrl_r[CTL_STAGE1_EN]) begin
            s1[ch] = first_order(xin[ch], x1_r[ch][0], y1_r[ch][0],
               17'($signed(stage1_r[13:0])),
               ctrl_r[CTL_STAGE1_SHAPE] ? 17'($signed(stage1_r[13:0]))
                                        : -17'($signed(stage1_r[13:0])),
               $signed(stage1_r[COEF_HI_LSB +: 14]));
         end else begin
            s1[ch] = xin[ch];
         end
         // shelf equaliser
         if (ctrl_r[CTL_SHELF_EN]) begin
            s2[ch] = first_order(s1[ch], x1_r[ch][1], y1_r[ch][1],
               17'($signed(shelf_ac_r[15:0])), 17'($signed(shelf_ac_r[31:16])),
               $signed(shelf_b_r[13:0]));
         end else begin
            s2[ch] = s1[ch];
         end
         // stage3 mutes when disabled
         if (ctrl_r[CTL_STAGE3_EN]) begin
            s3[ch] = first_order(s2[ch], x1_r[ch][2], y1_r[ch][2],
               17'($signed(stage3_r[13:0])),
               ctrl_r[CTL_STAGE3_SHAPE] ? 17'($signed(stage3_r[13:0]))
                                        : -17'($signed(stage3_r[13:0])),
               $signed(stage3_r[COEF_HI_LSB +: 14]));
         end else begin
            s3[ch] = 16'sh0000;
         end
         sv[ch] = vol_apply(s3[ch], vol_r[ch]);
         // zero crossing: sign change or exact zero
         zc[ch] = (sv[ch][15] != prev_r[ch][15]) || (sv[ch] == 16'sh0000);
      end
   end

   // either channel at or above the detection level
   assign hot = (mag(sv[0]) >= detect_level(ctrl_r[CTL_LMTH_LSB +: 2])) ||
                (mag(sv[1]) >= detect_level(ctrl_r[CTL_LMTH_LSB +: 2]));
   // below detection but at or above the band floor
   assign in_band = ~hot &&
      ((mag(sv[0]) >= band_floor(ctrl_r[CTL_LMTH_LSB +: 2])) ||
       (mag(sv[1]) >= band_floor(ctrl_r[CTL_LMTH_LSB +: 2])));

   // filter history, cleared when a stage is off or the path is down
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !(rec_sel | play_sel)) begin
         for (int ch = 0; ch < 2; ch++) begin
            for (int k = 0; k < 3; k++) begin
               x1_r[ch][k] <= 16'sh0000;
               y1_r[ch][k] <= 16'sh0000;
            end
            prev_r[ch] <= 16'sh0000;
         end
      end else if (tick) begin
         for (int ch = 0; ch < 2; ch++) begin
            x1_r[ch][0] <= ctrl_r[CTL_STAGE1_EN] ? xin[ch] : 16'sh0000;
            y1_r[ch][0] <= ctrl_r[CTL_STAGE1_EN] ? s1[ch] : 16'sh0000;
            x1_r[ch][1] <= ctrl_r[CTL_SHELF_EN] ? s1[ch] : 16'sh0000;
            y1_r[ch][1] <= ctrl_r[CTL_SHELF_EN] ? s2[ch] : 16'sh0000;
            x1_r[ch][2] <= ctrl_r[CTL_STAGE3_EN] ? s2[ch] : 16'sh0000;
            y1_r[ch][2] <= ctrl_r[CTL_STAGE3_EN] ? s3[ch] : 16'sh0000;
            prev_r[ch] <= sv[ch];
         end
      end
   end

   // output sample register and strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         proc_out <= '0;
         proc_valid <= 1'b0;
         path_rec <= 1'b0;
         path_play <= 1'b0;
         hot_r <= 1'b0;
         band_r <= 1'b0;
      end else begin
         proc_valid <= tick;
         path_rec <= rec_sel;
         path_play <= play_sel;
         if (tick) begin
            proc_out <= '{left: sv[0], right: sv[1]};
            hot_r <= hot;
            band_r <= in_band;
         end
      end
   end

   // limiter sequencing and shared volume
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lim_state_r <= LIM_IDLE;
         tmo_cnt_r <= 11'h000;
         target_r <= VOL_UNITY;
         applied_r <= 2'b00;
         vol_r[0] <= VOL_UNITY;
         vol_r[1] <= VOL_UNITY;
      end else if (!alc_on) begin
         // manual volume while level control is off
         lim_state_r <= LIM_IDLE;
         applied_r <= 2'b00;
         tmo_cnt_r <= 11'h000;
         if (wr_go && wb_adr_i == OFS_VOLUME) begin
            if (wb_sel_i[0]) begin
               vol_r[0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               vol_r[1] <= wb_dat_i[VOL_R_LSB +: 8];
            end
         end
      end else if (tick) begin
         case (lim_state_r)
            LIM_IDLE: begin
               if (hot) begin
                  // both channels go to one common, lower value
                  target_r <= (vmin > step) ? vmin - step : 8'h00;
                  if (zc_dis) begin
                     vol_r[0] <= (vmin > step) ? vmin - step : 8'h00;
                     vol_r[1] <= (vmin > step) ? vmin - step : 8'h00;
                  end else begin
                     lim_state_r <= LIM_PEND;
                     applied_r <= 2'b00;
                     tmo_cnt_r <= 11'h000;
                  end
               end
            end
            LIM_PEND: begin
               // each channel moves at its own crossing or at timeout
               tmo_cnt_r <= tmo_cnt_r + 11'h001;
               for (int ch = 0; ch < 2; ch++) begin
                  if (!applied_r[ch] && (zc[ch] || tmo_cnt_r + 11'h001 >= tmo_lim)) begin
                     vol_r[ch] <= target_r;
                  end
               end
               if ((applied_r | zc) == 2'b11 || tmo_cnt_r + 11'h001 >= tmo_lim) begin
                  lim_state_r <= LIM_IDLE;
                  applied_r <= 2'b00;
               end else begin
                  applied_r <= applied_r | zc;
               end
            end
            default: begin
               lim_state_r <= LIM_IDLE;
            end
         endcase
      end
   end

   // configuration registers, byte-enabled writes
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         stage1_r <= COEF_RST;
         stage3_r <= COEF_RST;
         shelf_ac_r <= COEF_RST;
         shelf_b_r <= COEF_RST;
      end else if (wr_go) begin
         case (wb_adr_i)
            OFS_CTRL: ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
            OFS_STAGE1: stage1_r <= merge(stage1_r, wb_dat_i, wb_sel_i);
            OFS_STAGE3: stage3_r <= merge(stage3_r, wb_dat_i, wb_sel_i);
            OFS_SHELF_AC: shelf_ac_r <= merge(shelf_ac_r, wb_dat_i, wb_sel_i);
            OFS_SHELF_B: shelf_b_r <= merge(shelf_b_r, wb_dat_i, wb_sel_i);
            default: begin
               // read-only or unmapped: ignored
            end
         endcase
      end
   end

   // status word: limiter state and last-sample levels
   assign status_w = {27'h0000000, band_r, hot_r, applied_r != 2'b00, path_play,
                      lim_state_r == LIM_PEND};
   // ack and read data, one wait state, ack drops after one cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
         if (wb_cyc_i && wb_stb_i && !ack_r) begin
            case (wb_adr_i)
               OFS_CTRL: dat_r <= ctrl_r & 32'h0007_3f7f;
               OFS_STAGE1: dat_r <= stage1_r & 32'h3fff_3fff;
               OFS_STAGE3: dat_r <= stage3_r & 32'h3fff_3fff;
               OFS_SHELF_AC: dat_r <= shelf_ac_r;
               OFS_SHELF_B: dat_r <= shelf_b_r & 32'h0000_3fff;
               OFS_VOLUME: dat_r <= {16'h0000, vol_r[1], vol_r[0]};
               OFS_STATUS: dat_r <= status_w;
               default: dat_r <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
endmodule : iir_filters_and_level_limiter

// [iir_alc_pkg.sv]
package iir_alc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAGE1 = 8'h04;
   localparam logic [7:0] OFS_STAGE3 = 8'h08;
   localparam logic [7:0] OFS_SHELF_AC = 8'h0c;
   localparam logic [7:0] OFS_SHELF_B = 8'h10;
   localparam logic [7:0] OFS_VOLUME = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   // control field positions
   localparam int CTL_STAGE1_EN = 0;
   localparam int CTL_STAGE1_SHAPE = 1;
   localparam int CTL_SHELF_EN = 2;
   localparam int CTL_STAGE3_EN = 3;
   localparam int CTL_STAGE3_SHAPE = 4;
   localparam int CTL_ALC_EN = 5;
   localparam int CTL_ZC_DIS = 6;
   localparam int CTL_ZTM_LSB = 8;
   localparam int CTL_LMTH_LSB = 10;
   localparam int CTL_LMAT_LSB = 12;
   localparam int CTL_ADC_L = 16;
   localparam int CTL_ADC_R = 17;
   localparam int CTL_DAC = 18;
   localparam int COEF_HI_LSB = 16;
   localparam int VOL_R_LSB = 8;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] COEF_RST = 32'h0000_0000;
   localparam logic [7:0] VOL_UNITY = 8'h91;
   // coefficients carry 13 fraction bits
   localparam int COEF_FRAC = 13;
   // volume mantissa has 14 fraction bits, 16 steps per 6 dB
   localparam int VOL_FRAC = 14;
   localparam logic [15:0] VOL_MANT [16] = '{
      16'h4000, 16'h42d5, 16'h45ca, 16'h48e0, 16'h4c19, 16'h4f77, 16'h52fa, 16'h56a6,
      16'h5a7b, 16'h5e7b, 16'h62a9, 16'h6706, 16'h6b95, 16'h7057, 16'h754f, 16'h7a7f};
   // zero crossing timeout base in sample periods
   localparam logic [10:0] ZTO_BASE = 11'h080;
   // level thresholds in 16-bit full scale
   localparam logic [16:0] LVL_M2P5 = 17'h05ffd;
   localparam logic [16:0] LVL_M4P1 = 17'h04fd6;
   localparam logic [16:0] LVL_M6P0 = 17'h04027;
   localparam logic [16:0] LVL_M8P5 = 17'h0301b;
   localparam logic [16:0] LVL_M12 = 17'h02027;
   // limiter states
   typedef enum logic [1:0] {LIM_IDLE = 2'b00, LIM_PEND = 2'b01} lim_state_e;
   // stereo sample carrier
   typedef struct packed {
      logic signed [15:0] left;
      logic signed [15:0] right;
   } stereo_s;
endpackage : iir_alc_pkg

// [iir_filters_and_level_limiter_properties.sv]
module iir_limiter_checker
   import iir_alc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // sample stream
   input wire logic rec_valid,
   input wire logic play_valid,
   input wire stereo_s proc_out,
   input wire logic proc_valid,
   input wire logic path_rec,
   input wire logic path_play
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // request still waiting for its answer
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // record strobe on a settled record path
   sequence s_rec_take;
      rec_valid && path_rec && $past(path_rec);
   endsequence
   // playback strobe on a settled playback path
   sequence s_play_take;
      play_valid && path_play && $past(path_play);
   endsequence
   a_ack_next_cycle: assert property (s_req |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus answer longer than one cycle");
   a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("bus answer without request");
   a_read_data_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
      else $error("read data moved outside an answer");
   a_rec_sample_answered: assert property (s_rec_take |=> proc_valid)
      else $error("record sample not answered");
   a_play_sample_answered: assert property (s_play_take |=> proc_valid)
      else $error("playback sample not answered");
   a_play_ignores_rec: assert property (rec_valid && !play_valid && path_play && $past(path_play) |=> !proc_valid)
      else $error("record strobe taken on playback path");
   a_paths_exclusive: assert property (!(path_rec && path_play))
      else $error("both paths active");
   a_valid_has_cause: assert property (proc_valid |-> $past(rec_valid || play_valid))
      else $error("processed sample without strobe");
   a_out_holds: assert property (!proc_valid |-> $stable(proc_out))
      else $error("processed sample moved between strobes");
endmodule : iir_limiter_checker

bind iir_filters_and_level_limiter iir_limiter_checker u_iir_limiter_checker (.clk_sys, .rst_n, .wb_cyc_i,
   .wb_stb_i, .wb_dat_o, .wb_ack_o, .rec_valid, .play_valid, .proc_out, .proc_valid, .path_rec, .path_play);

// [sample_source.sv]
module sample_source
   import iir_alc_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // converter words toward the block
   output stereo_s rec_in,
   output logic rec_valid,
   output stereo_s play_in,
   output logic play_valid
);
   // idle lines at time zero
   initial begin
      rec_in = '0;
      rec_valid = 1'h0;
      play_in = '0;
      play_valid = 1'h0;
   end
   // one stereo word, right is the negated left; strobes stay two cycles apart
   task automatic send(input logic signed [15:0] x, input logic play);
      stereo_s w;
      w.left = x;
      w.right = -x;
      @(posedge clk_sys);
      if (play) begin
         play_in <= w;
         play_valid <= 1'h1;
      end else begin
         rec_in <= w;
         rec_valid <= 1'h1;
      end
      @(posedge clk_sys);
      rec_valid <= 1'h0;
      play_valid <= 1'h0;
      // released word is not held, so stale data cannot pass
      rec_in <= ~w;
      play_in <= ~w;
   endtask : send
endmodule : sample_source

// [iir_filters_and_level_limiter_bench.sv]
module iir_filters_and_level_limiter_bench
   import iir_alc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // bench drive and design outputs
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic wb_ack_o, proc_valid, path_rec, path_play, rec_valid, play_valid;
   stereo_s rec_in, play_in, proc_out;
   int n_errors = 0;
   int tests_run = 0;
   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;
   iir_filters_and_level_limiter u_iir_filters_and_level_limiter (.clk_sys(clk_sys), .rst_n(rst_n),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rec_in(rec_in), .rec_valid(rec_valid),
      .play_in(play_in), .play_valid(play_valid), .proc_out(proc_out), .proc_valid(proc_valid),
      .path_rec(path_rec), .path_play(path_play));
   sample_source u_sample_source (.clk_sys(clk_sys), .rec_in(rec_in), .rec_valid(rec_valid),
      .play_in(play_in), .play_valid(play_valid));
   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // compare one value
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask : check
   // one classic wishbone cycle, bounded wait for the answer
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i <= 1'h0;
      if (n >= 20) begin
         n_errors++;
         finish_test();
      end
   endtask : wb
   // register read with comparison
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
      wb(1'h0, adr, 32'h0);
      check(what, exp, q);
   endtask : rd
   // one sample, judged one cycle later
   task automatic smp(input logic signed [15:0] x, input logic play, input logic v, input logic signed [15:0] e);
      u_sample_source.send(x, play);
      #1;
      check("valid", {31'h0, v}, {31'h0, proc_valid});
      if (v) check("sample", {e, -e}, proc_out);
   endtask : smp
   // clear history by power down, then two equal samples
   task automatic pair(input logic [31:0] ctl, input logic signed [15:0] x, e0, e1);
      wb(1'h1, OFS_CTRL, 32'h0);
      wb(1'h1, OFS_CTRL, ctl);
      smp(x, ctl[17:16] == 2'h0, 1'h1, e0);
      smp(x, ctl[17:16] == 2'h0, 1'h1, e1);
   endtask : pair
   // level control restart: stop, unity volume, enable
   task automatic alc(input logic [31:0] ctl);
      wb(1'h1, OFS_CTRL, 32'h0);
      wb(1'h1, OFS_VOLUME, 32'h9191);
      wb(1'h1, OFS_CTRL, ctl);
   endtask : alc
   // detection edge for one threshold code, volume and status just below and at the level
   task automatic level(input logic [1:0] c, input logic signed [15:0] l);
      logic [31:0] ctl;
      ctl = 32'h0001_0078 | ({30'h0, c} << CTL_LMTH_LSB);
      alc(ctl);
      repeat (2) u_sample_source.send(l - 16'sh1, 1'h0);
      rd(OFS_VOLUME, 32'h9191, "volume below level");
      rd(OFS_STATUS, 32'h10, "status in wait band");
      alc(ctl);
      repeat (2) u_sample_source.send(l, 1'h0);
      rd(OFS_VOLUME, 32'h9090, "volume at level");
      rd(OFS_STATUS, 32'h08, "status hot");
   endtask : level
   // reset values and an unmapped place
   task automatic t_regs();
      rd(OFS_CTRL, 32'h0, "control reset");
      rd(OFS_VOLUME, 32'h9191, "volume reset");
      wb(1'h1, 8'h1c, 32'hffff_ffff);
      rd(8'h1c, 32'h0, "unmapped");
      rd(OFS_CTRL, 32'h0, "control after unmapped");
      $display("test registers done");
   endtask : t_regs
   // third stage shapes, mute and negative pole
   task automatic t_stage3();
      wb(1'h1, OFS_STAGE3, 32'h0000_1000);
      pair(32'h0001_0018, 16'sd1000, 16'sd500, 16'sd1000);
      pair(32'h0001_0008, 16'sd1000, 16'sd500, 16'sd0);
      pair(32'h0001_0000, 16'sd1000, 16'sd0, 16'sd0);
      wb(1'h1, OFS_STAGE3, 32'h3000_1000);
      pair(32'h0001_0018, 16'sd1000, 16'sd500, 16'sd1250);
      wb(1'h1, OFS_STAGE3, 32'h0000_1000);
      $display("test third stage done");
   endtask : t_stage3
   // first stage at 0 dB passband and shelf stage
   task automatic t_stage1_shelf();
      wb(1'h1, OFS_STAGE1, 32'h0000_1000);
      pair(32'h0001_0019, 16'sd1000, 16'sd250, 16'sd250);
      pair(32'h0001_001b, 16'sd1000, 16'sd250, 16'sd750);
      wb(1'h1, OFS_SHELF_AC, 32'hf000_2000);
      wb(1'h1, OFS_SHELF_B, 32'h0);
      pair(32'h0001_001c, 16'sd1000, 16'sd500, 16'sd750);
      $display("test first stage and shelf done");
   endtask : t_stage1_shelf
   // path placement by power bits
   task automatic t_path();
      wb(1'h1, OFS_CTRL, 32'h0);
      smp(16'sd1000, 1'h0, 1'h0, 16'sd0);
      wb(1'h1, OFS_CTRL, 32'h0004_0018);
      #1;
      check("paths", 32'h1, {30'h0, path_rec, path_play});
      smp(16'sd1000, 1'h0, 1'h0, 16'sd0);
      smp(16'sd1000, 1'h1, 1'h1, 16'sd500);
      wb(1'h1, OFS_CTRL, 32'h0);
      wb(1'h1, OFS_CTRL, 32'h0006_0018);
      #1;
      check("paths", 32'h2, {30'h0, path_rec, path_play});
      smp(16'sd1000, 1'h1, 1'h0, 16'sd0);
      smp(16'sd1000, 1'h0, 1'h1, 16'sd500);
      $display("test path done");
   endtask : t_path
   // limiter without zero crossing, and switched off
   task automatic t_limit();
      level(2'h0, 16'sd24573);
      level(2'h1, 16'sd20438);
      level(2'h2, 16'sd16423);
      level(2'h3, 16'sd12315);
      alc(32'h0001_3c78);
      repeat (3) u_sample_source.send(16'sd30000, 1'h0);
      rd(OFS_VOLUME, 32'h8e8e, "one step per hot sample");
      alc(32'h0001_3c58);
      repeat (3) u_sample_source.send(16'sd30000, 1'h0);
      rd(OFS_VOLUME, 32'h9191, "limiter off");
      $display("test limiter done");
   endtask : t_limit
   // zero crossing step and timeout
   task automatic t_cross();
      alc(32'h0001_3c38);
      u_sample_source.send(16'sd30000, 1'h0);
      wb(1'h1, OFS_VOLUME, 32'h0);
      rd(OFS_VOLUME, 32'h9191, "held until crossing");
      u_sample_source.send(-16'sd30000, 1'h0);
      rd(OFS_VOLUME, 32'h8989, "eight steps at crossing");
      alc(32'h0001_0c38);
      u_sample_source.send(16'sd30000, 1'h0);
      repeat (100) u_sample_source.send(16'sd50, 1'h0);
      rd(OFS_VOLUME, 32'h9191, "before timeout");
      repeat (40) u_sample_source.send(16'sd50, 1'h0);
      rd(OFS_VOLUME, 32'h9090, "after timeout");
      // longest timeout code
      alc(32'h0001_0f38);
      u_sample_source.send(16'sd30000, 1'h0);
      repeat (1000) u_sample_source.send(16'sd50, 1'h0);
      rd(OFS_VOLUME, 32'h9191, "before long timeout");
      repeat (40) u_sample_source.send(16'sd50, 1'h0);
      rd(OFS_VOLUME, 32'h9090, "after long timeout");
      $display("test zero crossing done");
   endtask : t_cross
   // main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'h1;
      t_regs();
      t_stage3();
      t_stage1_shelf();
      t_path();
      t_limit();
      t_cross();
      finish_test();
   end
endmodule : iir_filters_and_level_limiter_bench
